// ==== include/sesp_defs.svh ====
/*
 * Constants of the serial EEPROM slave: timing figures and derived
 * cycle counts, bus idle levels and the fixed slave address type.
 * Assumes the system clock period given by SESP_CLK_NS.
 */
`ifndef SESP_DEFS_SVH
`define SESP_DEFS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define SESP_CLK_NS 40
`define SESP_FILT_NS 250
`define SESP_HOLD_NS 300
`define SESP_WR1_MS 20
`define SESP_WR2_MS 40
// Least times round up
`define SESP_FILT_CYC ((`SESP_FILT_NS + `SESP_CLK_NS - 1) / `SESP_CLK_NS)
`define SESP_HOLD_CYC ((`SESP_HOLD_NS + `SESP_CLK_NS - 1) / `SESP_CLK_NS)
`define SESP_WR1_CYC ((`SESP_WR1_MS * 1000000) / `SESP_CLK_NS)
`define SESP_WR2_CYC ((`SESP_WR2_MS * 1000000) / `SESP_CLK_NS)

// ****************************************
// Address, bit positions and reset values
// ****************************************
`define SESP_DEV_TYPE 4'ha
`define SESP_ACK_SLOT 4'h8
`define SESP_LAST_BIT 4'h7
// Bit count preset at START: the START's own SCL fall wraps it to zero
`define SESP_BIT_PRE 4'hf
`define SESP_PTR_RST 8'h00
`define SESP_LINE_IDLE 1'b1

`endif

// ==== include/sesp_pkg.sv ====
/*
 * Types of the serial EEPROM slave.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sesp_pkg;

  typedef enum logic [2:0] {
    SESP_IDLE = 3'b000,
    SESP_DEVADR = 3'b001,
    SESP_WADR = 3'b010,
    SESP_WDATA = 3'b011,
    SESP_READ = 3'b100,
    SESP_SKIP = 3'b101
  } sesp_state_e;

  typedef logic [7:0] sesp_byte_t;

endpackage

// ==== rtl/sesp_filter.sv ====
/*
 * One bus line: two-flop synchroniser then a pulse filter that passes
 * a new level only after it has stood for CYC clocks.
 * Assumes an asynchronous pin input and a synchronous active-low reset.
 */
`timescale 1ns/1ns
`include "sesp_defs.svh"

module sesp_filter #(
  parameter int CYC = `SESP_FILT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Line
  input wire logic line_i,
  output logic line_o
);

  logic meta_r, sync_r, out_r, out_nxt;
  logic [7:0] cnt_r, cnt_nxt;

  always_comb begin
    out_nxt = out_r;
    cnt_nxt = 8'h00;
    if (sync_r != out_r) begin
      if (cnt_r >= 8'(CYC - 1)) begin
        out_nxt = sync_r;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= `SESP_LINE_IDLE;
      sync_r <= `SESP_LINE_IDLE;
      out_r <= `SESP_LINE_IDLE;
      cnt_r <= 8'h00;
    end else begin
      meta_r <= line_i;
      sync_r <= meta_r;
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign line_o = out_r;

endmodule

// ==== rtl/sesp_slave.sv ====
/*
 * Two-wire serial EEPROM slave: condition decode, address match,
 * write buffering with self-timed commit, sequential reads, 256 bytes.
 * Assumes open-drain SCL/SDA resolved outside, SCL oversampled by clk_sys.
 */
`timescale 1ns/1ns
`include "sesp_defs.svh"

module sesp_slave
  import sesp_pkg::*;
#(
  parameter int FILT_CYC = `SESP_FILT_CYC,
  parameter int HOLD_CYC = `SESP_HOLD_CYC,
  parameter int WR1_CYC = `SESP_WR1_CYC,
  parameter int WR2_CYC = `SESP_WR2_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps
  input wire logic chip_addr_strap_bit0,
  input wire logic chip_addr_strap_bit1,
  input wire logic chip_addr_strap_bit2,
  // Status
  output logic busy
);

  // ****************************************
  // Line filters
  // ****************************************
  logic [1:0] pin_in, pin_f;
  logic [2:0] strap_meta_r, strap_r;
  assign pin_in = {sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      sesp_filter #(.CYC(FILT_CYC)) u_filt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .line_i(pin_in[gi]),
        .line_o(pin_f[gi])
      );
    end
  endgenerate

  logic scl_f, sda_f;
  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];

  // ****************************************
  // State
  // ****************************************
  sesp_state_e state_r, state_nxt;
  logic [3:0] bit_r, bit_nxt;
  sesp_byte_t shift_r, shift_nxt, tx_r, tx_nxt;
  sesp_byte_t ptr_r, ptr_nxt, waddr_r, waddr_nxt;
  sesp_byte_t wbuf0_r, wbuf0_nxt, wbuf1_r, wbuf1_nxt;
  logic [1:0] nbytes_r, nbytes_nxt;
  logic rd_first_r, rd_first_nxt, mack_r, mack_nxt;
  logic drive_r, drive_nxt, oe_r, oe_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic busy_r, busy_nxt, wtwo_r, wtwo_nxt;
  logic [19:0] timer_r, timer_nxt;
  logic scl_prev_r, sda_prev_r;
  logic rise, fall, start_ev, stop_ev, match, mem_we;
  sesp_byte_t rd_addr;
  sesp_byte_t mem [256];

  assign rise = scl_f & ~scl_prev_r;
  assign fall = ~scl_f & scl_prev_r;
  assign start_ev = scl_f & scl_prev_r & sda_prev_r & ~sda_f;
  assign stop_ev = scl_f & scl_prev_r & ~sda_prev_r & sda_f;
  assign match = (shift_r[7:1] == {`SESP_DEV_TYPE, strap_r});
  assign mem_we = busy_r && (timer_r == 20'h00001);

  always_comb begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    waddr_nxt = waddr_r;
    wbuf0_nxt = wbuf0_r;
    wbuf1_nxt = wbuf1_r;
    nbytes_nxt = nbytes_r;
    rd_first_nxt = rd_first_r;
    mack_nxt = mack_r;
    drive_nxt = drive_r;
    busy_nxt = busy_r;
    wtwo_nxt = wtwo_r;
    timer_nxt = timer_r;
    rd_addr = ptr_r;
    if (busy_r) begin
      timer_nxt = timer_r - 20'h00001;
      if (timer_r == 20'h00001) begin
        busy_nxt = 1'b0;
      end
    end
    if (stop_ev) begin
      state_nxt = SESP_IDLE;
      bit_nxt = 4'h0;
      drive_nxt = 1'b0;
      if (state_r == SESP_WDATA && nbytes_r != 2'd0 && !busy_r) begin
        busy_nxt = 1'b1;
        wtwo_nxt = (nbytes_r == 2'd2);
        timer_nxt = (nbytes_r == 2'd2) ? 20'(WR2_CYC) : 20'(WR1_CYC);
      end
    end else if (start_ev) begin
      state_nxt = SESP_DEVADR;
      bit_nxt = `SESP_BIT_PRE;
      drive_nxt = 1'b0;
      nbytes_nxt = 2'd0;
    end else if (rise && state_r != SESP_IDLE && state_r != SESP_SKIP) begin
      if (bit_r < `SESP_ACK_SLOT) begin
        shift_nxt = {shift_r[6:0], sda_f};
      end else begin
        mack_nxt = ~sda_f;
      end
    end else if (fall && state_r != SESP_IDLE && state_r != SESP_SKIP) begin
      unique case (bit_r)
        `SESP_LAST_BIT: begin
          bit_nxt = `SESP_ACK_SLOT;
          drive_nxt = 1'b0;
          unique case (state_r)
            SESP_DEVADR: begin
              if (match && !busy_r) begin
                drive_nxt = 1'b1;
                rd_first_nxt = 1'b1;
                state_nxt = shift_r[0] ? SESP_READ : SESP_WADR;
              end else begin
                state_nxt = SESP_SKIP;
              end
            end
            SESP_WADR: begin
              ptr_nxt = shift_r;
              waddr_nxt = shift_r;
              drive_nxt = 1'b1;
              state_nxt = SESP_WDATA;
            end
            SESP_WDATA: begin
              if (nbytes_r == 2'd0) begin
                wbuf0_nxt = shift_r;
              end else if (nbytes_r == 2'd1) begin
                wbuf1_nxt = shift_r;
              end
              if (nbytes_r != 2'd2) begin
                nbytes_nxt = nbytes_r + 2'd1;
                ptr_nxt = ptr_r + 8'h01;
                drive_nxt = 1'b1;
              end else begin
                // Excess byte: no acknowledge, buffered pair still commits at STOP
                drive_nxt = 1'b0;
              end
            end
            default: begin
              drive_nxt = 1'b0;
            end
          endcase
        end
        `SESP_ACK_SLOT: begin
          bit_nxt = 4'h0;
          drive_nxt = 1'b0;
          if (state_r == SESP_READ) begin
            if (rd_first_r || mack_r) begin
              rd_addr = rd_first_r ? ptr_r : ptr_r + 8'h01;
              ptr_nxt = rd_addr;
              tx_nxt = mem[rd_addr];
              drive_nxt = ~mem[rd_addr][7];
              rd_first_nxt = 1'b0;
            end else begin
              state_nxt = SESP_SKIP;
            end
          end
        end
        default: begin
          bit_nxt = bit_r + 4'h1;
          if (state_r == SESP_READ) begin
            tx_nxt = {tx_r[6:0], 1'b0};
            drive_nxt = ~tx_r[6];
          end
        end
      endcase
    end
  end

  // output change waits out the fall
  always_comb begin
    oe_nxt = oe_r;
    hold_nxt = hold_r;
    if (drive_nxt != drive_r) begin
      hold_nxt = 8'(HOLD_CYC);
    end else if (hold_r != 8'h00) begin
      hold_nxt = hold_r - 8'h01;
      if (hold_r == 8'h01) begin
        oe_nxt = drive_r;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= SESP_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= `SESP_PTR_RST;
      waddr_r <= 8'h00;
      wbuf0_r <= 8'h00;
      wbuf1_r <= 8'h00;
      nbytes_r <= 2'd0;
      rd_first_r <= 1'b0;
      mack_r <= 1'b0;
      drive_r <= 1'b0;
      oe_r <= 1'b0;
      hold_r <= 8'h00;
      busy_r <= 1'b0;
      wtwo_r <= 1'b0;
      timer_r <= 20'h00000;
      scl_prev_r <= `SESP_LINE_IDLE;
      sda_prev_r <= `SESP_LINE_IDLE;
      strap_meta_r <= 3'h0;
      strap_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      waddr_r <= waddr_nxt;
      wbuf0_r <= wbuf0_nxt;
      wbuf1_r <= wbuf1_nxt;
      nbytes_r <= nbytes_nxt;
      rd_first_r <= rd_first_nxt;
      mack_r <= mack_nxt;
      drive_r <= drive_nxt;
      oe_r <= oe_nxt;
      hold_r <= hold_nxt;
      busy_r <= busy_nxt;
      wtwo_r <= wtwo_nxt;
      timer_r <= timer_nxt;
      scl_prev_r <= scl_f;
      sda_prev_r <= sda_f;
      strap_meta_r <= {chip_addr_strap_bit2, chip_addr_strap_bit1, chip_addr_strap_bit0};
      strap_r <= strap_meta_r;
    end
  end

  // ****************************************
  // Storage array
  // ****************************************
  // Bytes land at the end of the cycle, reads before then see old data
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[waddr_r] <= wbuf0_r;
      if (wtwo_r) begin
        mem[waddr_r + 8'h01] <= wbuf1_r;
      end
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
  assign busy = busy_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_stop_to_idle: assert property (stop_ev |=> state_r == SESP_IDLE)
    else $error("stop did not return to idle");
  a_start_to_addr: assert property (start_ev |=> state_r == SESP_DEVADR && bit_r == `SESP_BIT_PRE)
    else $error("start did not begin address phase");
  a_busy_from_stop: assert property ($rose(busy_r) |-> $past(stop_ev))
    else $error("write cycle began without stop");
  a_timer_length: assert property ($rose(busy_r) |->
      timer_r == (wtwo_r ? 20'(WR2_CYC) : 20'(WR1_CYC)))
    else $error("write time does not match byte count");
  a_no_ack_busy: assert property (busy_r && fall && !stop_ev && !start_ev &&
      bit_r == `SESP_LAST_BIT && state_r == SESP_DEVADR |=> !drive_r)
    else $error("acknowledged while busy");
  a_skip_silent: assert property (state_r == SESP_SKIP |-> !drive_r)
    else $error("drove bus while skipping");
  a_wadr_ack: assert property (fall && !stop_ev && !start_ev &&
      bit_r == `SESP_LAST_BIT && state_r == SESP_WADR |=> drive_r && ptr_r == $past(shift_r))
    else $error("word address not acknowledged and loaded");
  a_hold_delay: assert property ($changed(drive_r) |=> $stable(sda_oe))
    else $error("output changed without hold");
  a_ptr_on_ack: assert property ($changed(ptr_r) && $past(state_r) == SESP_READ |->
      $past(rd_first_r) || $past(mack_r))
    else $error("pointer moved without acknowledge");
  a_nack_release: assert property (fall && !stop_ev && !start_ev && state_r == SESP_READ &&
      bit_r == `SESP_ACK_SLOT && !rd_first_r && !mack_r |=> state_r == SESP_SKIP && !drive_r)
    else $error("kept driving after missing acknowledge");

  c_write_two: cover property ($rose(busy_r) && wtwo_r);
  c_seq_read: cover property (state_r == SESP_READ && mack_r && fall && bit_r == `SESP_ACK_SLOT);
  c_busy_poll: cover property (busy_r && state_r == SESP_SKIP);
  c_cur_read: cover property (state_r == SESP_DEVADR ##1 state_r == SESP_READ);

endmodule

// ==== sim/sesp_master.sv ====
/*
 * Bus master model for the two-wire slave: START, STOP, byte out, byte in.
 * Assumes SDA is resolved outside as a wired-AND with a pull-up.
 */
`timescale 1ns/1ns

module sesp_master (
  // Bus
  output logic scl,
  output logic sda_drv,
  // Resolved SDA
  input wire logic sda_in
);
  // Low phase stretched: the slave answers some 280 ns after a fall
  localparam int TL = 400;
  localparam int TH = 160;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ****************************************
  // Bus tasks, each but stop ends with SCL low
  // ****************************************
  // SDA moves only with SCL low
  task automatic bit_io(input logic b, output logic s);
    #80 sda_drv = b;
    #(TL - 80) scl = 1'b1;
    #120 s = sda_in;
    #40 scl = 1'b0;
  endtask

  task automatic start();
    #80 sda_drv = 1'b1;
    #(TL - 80) scl = 1'b1;
    #TH sda_drv = 1'b0;
    #TH scl = 1'b0;
  endtask

  task automatic stop();
    #80 sda_drv = 1'b0;
    #(TL - 80) scl = 1'b1;
    #TH sda_drv = 1'b1;
    #TH;
  endtask

  // runt SCL pulse, shorter than the filter
  task automatic runt();
    #80 scl = 1'b1;
    #40 scl = 1'b0;
  endtask

  // MSB first, slave ack on ninth
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // master acks or withholds on ninth
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask
endmodule

// ==== sim/serial_eeprom_slave_protocol_tb.sv ====
/*
 * Bench for the serial EEPROM slave: writes, busy polling, reads, address match.
 * Assumes the master model and short write times set by parameter.
 */
`timescale 1ns/1ns
`include "sesp_defs.svh"

module serial_eeprom_slave_protocol_tb
  import sesp_pkg::*;
;
  localparam int W1 = 200;
  localparam int W2 = 400;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl;
  logic sda_drv;
  logic sda_o;
  logic sda_oe;
  logic busy;
  wire logic sda_line = sda_drv & ~(sda_oe & ~sda_o);
  int errors = 0;
  int num_checks = 0;
  int busy_cnt = 0;

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  sesp_master m (.scl(scl), .sda_drv(sda_drv), .sda_in(sda_line));

  sesp_slave #(.FILT_CYC(2), .HOLD_CYC(2), .WR1_CYC(W1), .WR2_CYC(W2)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_addr_strap_bit0(strap[0]),
    .chip_addr_strap_bit1(strap[1]), .chip_addr_strap_bit2(strap[2]), .busy(busy));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic sesp_byte_t dev(input logic [2:0] a, input logic rw);
    return {`SESP_DEV_TYPE, a, rw};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic do_write(input sesp_byte_t p, input sesp_byte_t d[3], input int n,
                          input logic poll);
    logic a;
    int c0;
    m.start();
    m.send(dev(strap, 1'b0), a); chk(a, 1'b1);
    m.send(p, a); chk(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.send(d[i], a); chk(a, i < 2);
    end
    chk(busy, 1'b0);
    c0 = busy_cnt;
    m.stop();
    if (poll) begin
      m.start();
      m.send(dev(strap, 1'b0), a); chk(a, 1'b0);
      m.stop();
    end
    repeat (W2 + 40) @(posedge clk_sys);
    #1;
    chk(busy_cnt - c0, n == 1 ? W1 : W2);
  endtask

  task automatic do_read(input logic rnd, input sesp_byte_t p, input sesp_byte_t e[3],
                         input int n);
    logic a;
    sesp_byte_t d;
    m.start();
    if (rnd) begin
      m.send(dev(strap, 1'b0), a);
      m.send(p, a); chk(a, 1'b1);
      m.start();
    end
    m.send(dev(strap, 1'b1), a); chk(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.recv(i < n - 1, d); chk(d, e[i]);
    end
    #400 chk(sda_oe, 1'b0);
    m.stop();
  endtask

  // A counted runt clock would shift the address and lose the acknowledge
  task automatic do_runt();
    logic a;
    m.start();
    m.runt();
    m.send(dev(strap, 1'b0), a); chk(a, 1'b1);
    m.stop();
  endtask

  task automatic addr_scan();
    logic a;
    for (int i = 0; i < 8; i++) begin
      m.start();
      m.send(dev(i[2:0], 1'b0), a); chk(a, i[2:0] == strap);
      m.stop();
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk(busy, 1'b0);
    chk(sda_oe, 1'b0);
    do_write(8'h10, '{8'h5a, 8'hc3, 8'h00}, 2, 1'b1);
    do_write(8'h20, '{8'h96, 8'h00, 8'h00}, 1, 1'b0);
    do_write(8'h1e, '{8'h11, 8'h22, 8'h33}, 3, 1'b0);
    do_write(8'hff, '{8'he7, 8'h3c, 8'h00}, 2, 1'b0);
    do_read(1'b1, 8'h10, '{8'h5a, 8'hc3, 8'h00}, 2);
    do_read(1'b0, 8'h00, '{8'hc3, 8'h00, 8'h00}, 1);
    do_read(1'b1, 8'h1e, '{8'h11, 8'h22, 8'h96}, 3);
    do_read(1'b1, 8'hff, '{8'he7, 8'h3c, 8'h00}, 2);
    do_runt();
    addr_scan();
    strap = 3'h2;
    #400 addr_scan();
    give_verdict();
  end

  initial begin
    #3000000;
    errors++;
    give_verdict();
  end
endmodule
